//--- acr_cfg.svh
// offsets, field positions, reset values, widths and channel count of the channel and resampler register bank
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH

`define ACR_ADDR_W          7
`define ACR_DATA_W          8
`define ACR_NUM_CHAN        6
// register offsets
`define ACR_OFF_CHAN_BASE   7'h00
`define ACR_OFF_DIAG_STATUS 7'h5F
`define ACR_OFF_INT_HI      7'h60
`define ACR_OFF_INT_LO      7'h61
`define ACR_OFF_FRAC_HI     7'h62
`define ACR_OFF_FRAC_LO     7'h63
`define ACR_OFF_LOAD_CTRL   7'h64
// reset values
`define ACR_RST_CHAN        8'h00
`define ACR_RST_INT_HI      8'h00
`define ACR_RST_INT_LO      8'h80
`define ACR_RST_FRAC_HI     8'h00
`define ACR_RST_FRAC_LO     8'h00
`define ACR_RST_LOAD_CTRL   8'h00
`define ACR_RST_STATUS      8'h00
// channel setup fields
`define ACR_GAIN_HI         7
`define ACR_GAIN_LO         6
`define ACR_VREF_BIT        5
`define ACR_METER_BIT       4
// load control fields and integer ratio high mask
`define ACR_LOAD_SRC_BIT    7
`define ACR_LOAD_UPD_BIT    0
`define ACR_INT_HI_MASK     8'h0F
// status fields
`define ACR_STAT_FAULT_BIT  5
`define ACR_STAT_INIT_BIT   4
// ratio widths
`define ACR_INT_W           12
`define ACR_FRAC_W          16

`endif

//--- acr_pkg.sv
// types shared by the channel and resampler register bank
package acr_pkg;

   // amplifier gain codes
   typedef enum logic [1:0] {
      acr_gain_x1_type_v = 2'b00,
      acr_gain_x2_type_v = 2'b01,
      acr_gain_x4_type_v = 2'b10,
      acr_gain_x8_type_v = 2'b11
   } acr_gain_type;

   // ratio apply sequencer states
   typedef enum logic [1:0] {
      acr_st_idle  = 2'b00,
      acr_st_apply = 2'b01,
      acr_st_done  = 2'b10
   } acr_load_state_type;

endpackage

//--- acr_chan_mem.sv
// storage for the per-channel front-end setup bytes, registered read port
`timescale 1ns/1ps
`include "acr_cfg.svh"

module acr_chan_mem (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      ce,
   input  wire logic                      wr_en,
   input  wire logic [2:0]                wr_idx,
   input  wire logic [`ACR_DATA_W-1:0]    wr_data,
   input  wire logic [2:0]                rd_idx,
   output logic      [`ACR_DATA_W-1:0]    rd_data,
   output logic      [`ACR_NUM_CHAN*8-1:0] all_data
);

   logic [`ACR_DATA_W-1:0] mem [0:`ACR_NUM_CHAN-1];

   // one byte per channel, whole byte stored including the reserved nibble
   genvar g;
   generate
      for (g = 0; g < `ACR_NUM_CHAN; g = g + 1) begin : g_ch
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               mem[g] <= `ACR_RST_CHAN;
            end else if (ce && wr_en && wr_idx == 3'(g)) begin
               mem[g] <= wr_data; // RL5
            end
         end
         assign all_data[g*8 +: 8] = mem[g];
      end
   endgenerate

   // registered read; out-of-range index reads zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_data <= 8'h00;
      end else if (ce) begin
         rd_data <= (rd_idx < 3'(`ACR_NUM_CHAN)) ? mem[rd_idx] : 8'h00;
      end
   end

endmodule

//--- acr_ratio_load.sv
// resampler ratio apply sequencer: moves staged ratio into the active copy on a trigger
`timescale 1ns/1ps
`include "acr_cfg.svh"

module acr_ratio_load (
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire logic                     ce,
   input  wire logic                     trigger,
   input  wire logic [`ACR_INT_W-1:0]    staged_int,
   input  wire logic [`ACR_FRAC_W-1:0]   staged_frac,
   output logic      [`ACR_INT_W-1:0]    active_int,
   output logic      [`ACR_FRAC_W-1:0]   active_frac,
   output logic                          applied
);

   acr_pkg::acr_load_state_type state;
   acr_pkg::acr_load_state_type next_state;

   // next state: a trigger starts one apply cycle, then one done cycle
   always_comb begin
      next_state = state;
      case (state)
         acr_pkg::acr_st_idle: begin
            if (trigger) begin
               next_state = acr_pkg::acr_st_apply;
            end
         end
         acr_pkg::acr_st_apply: next_state = acr_pkg::acr_st_done;
         acr_pkg::acr_st_done:  next_state = acr_pkg::acr_st_idle;
         default:               next_state = acr_pkg::acr_st_idle;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= acr_pkg::acr_st_idle;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // active ratio only changes in the apply state, so partial writes never leak out
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         active_int  <= {4'h0, `ACR_RST_INT_LO};
         active_frac <= 16'h0000;
         applied     <= 1'b0;
      end else if (ce) begin
         applied <= (state == acr_pkg::acr_st_apply);
         if (state == acr_pkg::acr_st_apply) begin
            active_int  <= staged_int;   // RL12
            active_frac <= staged_frac;  // RL12
         end
      end
   end

endmodule

//--- acr_regs.sv
// channel front-end setup and resampler ratio register bank
// Behaviour
// [RL1] six 8-bit channel setup registers at 0x000 upward, all reset to zero
// [RL2] bits 7:6 pick gain: 00 one, 01 two, 10 four, 11 eight
// [RL3] bit 5 dedicates the channel to reference monitoring, clears on reset
// [RL4] bit 4 puts the channel input mux into meter receive mode
// [RL5] low nibble reserved: read-write storage, resets zero, no function
// [RL6] channel five setup sits at 0x005 with identical layout and reset
// [RL7] 12-bit integer ratio split hi nibble at 0x060, low byte 0x061, reset 0x80
// [RL8] 16-bit fractional ratio, high byte 0x062, low byte 0x063, reset zero
// [RL9] load control 0x064: bit 7 source select, bit 0 update, reset zero
// [RL10] status 0x05F: bit 5 chip fault, bit 4 init done, bits 3:0 pair saturation
// [RL11] integer ratio high register keeps bits 7:4 reserved, resets zero
// [RL12] ratio changes take effect only after a load trigger
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "acr_cfg.svh"

module acr_regs (
   clk,
   rst,
   ce,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   chip_fault_in,
   init_done_in,
   sat_fault_in,
   gpio_load_in,
   amp_gain_code,
   vref_watch,
   meter_receive,
   resample_int_ratio,
   resample_frac_ratio,
   resample_trigger_select,
   resample_applied
);

   input  wire logic                          clk;
   input  wire logic                          rst;
   input  wire logic                          ce;
   input  wire logic [`ACR_ADDR_W-1:0]        reg_addr;
   input  wire logic [`ACR_DATA_W-1:0]        reg_wdata;
   input  wire logic                          reg_wr;
   input  wire logic                          reg_rd;
   output logic      [`ACR_DATA_W-1:0]        reg_rdata;
   input  wire logic                          chip_fault_in;
   input  wire logic                          init_done_in;
   input  wire logic [3:0]                    sat_fault_in;
   input  wire logic                          gpio_load_in;
   output logic      [`ACR_NUM_CHAN*2-1:0]    amp_gain_code;
   output logic      [`ACR_NUM_CHAN-1:0]      vref_watch;
   output logic      [`ACR_NUM_CHAN-1:0]      meter_receive;
   output logic      [`ACR_INT_W-1:0]         resample_int_ratio;
   output logic      [`ACR_FRAC_W-1:0]        resample_frac_ratio;
   output logic                               resample_trigger_select;
   output logic                               resample_applied;

   // =======================================================
   // decode helpers
   // =======================================================

   // true when the address falls on a channel setup register
   function automatic logic is_chan(input logic [`ACR_ADDR_W-1:0] a);
      is_chan = (a < (`ACR_OFF_CHAN_BASE + 7'(`ACR_NUM_CHAN)));
   endfunction

   // channel index from address
   function automatic logic [2:0] chan_idx(input logic [`ACR_ADDR_W-1:0] a);
      chan_idx = 3'(a - `ACR_OFF_CHAN_BASE);
   endfunction

   // =======================================================
   // input synchronisers for status pins from outside logic
   // =======================================================
   logic [6:0] stat_meta;
   logic [6:0] stat_sync;
   logic       gpio_meta;
   logic       gpio_sync;
   logic       gpio_prev;

   // two flops before anything reads the pins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stat_meta <= 7'h00;
         stat_sync <= 7'h00;
         gpio_meta <= 1'b0;
         gpio_sync <= 1'b0;
         gpio_prev <= 1'b0;
      end else if (ce) begin
         stat_meta <= {chip_fault_in, init_done_in, sat_fault_in, 1'b0};
         stat_sync <= stat_meta;
         gpio_meta <= gpio_load_in;
         gpio_sync <= gpio_meta;
         gpio_prev <= gpio_sync;
      end
   end

   // =======================================================
   // channel setup storage
   // =======================================================
   logic                        chan_wr;
   logic [`ACR_NUM_CHAN*8-1:0]  chan_all;

   assign chan_wr = reg_wr && is_chan(reg_addr); // RL1 RL6

   acr_chan_mem u_chan_mem (
      .clk      (clk),
      .rst      (rst),
      .ce       (ce),
      .wr_en    (chan_wr),
      .wr_idx   (chan_idx(reg_addr)),
      .wr_data  (reg_wdata),
      .rd_idx   (chan_idx(reg_addr)),
      .rd_data  (),
      .all_data (chan_all)
   );

   // fields fanned out per channel, registered so outputs come from flops
   genvar c;
   generate
      for (c = 0; c < `ACR_NUM_CHAN; c = c + 1) begin : g_fld
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               amp_gain_code[c*2 +: 2] <= 2'b00;
               vref_watch[c]           <= 1'b0;
               meter_receive[c]        <= 1'b0;
            end else if (ce) begin
               amp_gain_code[c*2 +: 2] <= chan_all[c*8+`ACR_GAIN_LO +: 2]; // RL2
               vref_watch[c]           <= chan_all[c*8+`ACR_VREF_BIT];     // RL3
               meter_receive[c]        <= chan_all[c*8+`ACR_METER_BIT];    // RL4
            end
         end
      end
   endgenerate
   // bits 3:0 are stored but drive nothing: RL5

   // =======================================================
   // resampler ratio staging registers
   // =======================================================
   logic [3:0]              int_hi;
   logic [`ACR_DATA_W-1:0]  int_lo;
   logic [`ACR_DATA_W-1:0]  frac_hi;
   logic [`ACR_DATA_W-1:0]  frac_lo;
   logic                    load_src;
   logic                    load_upd;

   // staged copies; writing them alone changes nothing downstream
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         int_hi  <= 4'h0;             // RL11
         int_lo  <= `ACR_RST_INT_LO;  // RL7
         frac_hi <= `ACR_RST_FRAC_HI; // RL8
         frac_lo <= `ACR_RST_FRAC_LO; // RL8
      end else if (ce && reg_wr) begin
         case (reg_addr)
            `ACR_OFF_INT_HI:  int_hi  <= reg_wdata[3:0]; // RL11
            `ACR_OFF_INT_LO:  int_lo  <= reg_wdata;      // RL7
            `ACR_OFF_FRAC_HI: frac_hi <= reg_wdata;      // RL8
            `ACR_OFF_FRAC_LO: frac_lo <= reg_wdata;      // RL8
            default: begin
            end
         endcase
      end
   end

   // load control: source select and update bit; reserved bits read zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         load_src <= 1'b0; // RL9
         load_upd <= 1'b0; // RL9
      end else if (ce && reg_wr && reg_addr == `ACR_OFF_LOAD_CTRL) begin
         load_src <= reg_wdata[`ACR_LOAD_SRC_BIT]; // RL9
         load_upd <= reg_wdata[`ACR_LOAD_UPD_BIT]; // RL9
      end
   end

   // =======================================================
   // load trigger
   // =======================================================
   logic load_trigger;
   logic upd_prev;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         upd_prev <= 1'b0;
      end else if (ce) begin
         upd_prev <= load_upd;
      end
   end

   // software source: update bit rising; pin source: synced pin rising
   // level-sensitive triggers were avoided so a stuck bit cannot keep reloading
   assign load_trigger = load_src ? (gpio_sync && !gpio_prev)
                                  : (load_upd && !upd_prev); // RL12

   acr_ratio_load u_ratio_load (
      .clk         (clk),
      .rst         (rst),
      .ce          (ce),
      .trigger     (load_trigger),
      .staged_int  ({int_hi, int_lo}),
      .staged_frac ({frac_hi, frac_lo}),
      .active_int  (resample_int_ratio),
      .active_frac (resample_frac_ratio),
      .applied     (resample_applied)
   );

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         resample_trigger_select <= 1'b0;
      end else if (ce) begin
         resample_trigger_select <= load_src;
      end
   end

   // =======================================================
   // status and read path
   // =======================================================
   logic [`ACR_DATA_W-1:0] status_val;
   logic [`ACR_DATA_W-1:0] next_rdata;

   // status built from synced pins; bits 7:6 reserved zero
   assign status_val = {2'b00, stat_sync[6], stat_sync[5], stat_sync[4:1]}; // RL10

   // non-channel read mux, unmapped addresses read zero
   always_comb begin
      next_rdata = 8'h00;
      case (reg_addr)
         `ACR_OFF_DIAG_STATUS: next_rdata = status_val;                // RL10
         `ACR_OFF_INT_HI:      next_rdata = {4'h0, int_hi};           // RL11
         `ACR_OFF_INT_LO:      next_rdata = int_lo;
         `ACR_OFF_FRAC_HI:     next_rdata = frac_hi;
         `ACR_OFF_FRAC_LO:     next_rdata = frac_lo;
         `ACR_OFF_LOAD_CTRL:   next_rdata = {load_src, 6'h00, load_upd}; // RL9
         default:              next_rdata = 8'h00;
      endcase
   end

   // one read-data flop; channel bytes are picked from the stored array so the port leaves a register
   // and the data still stand in the cycle right after the strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (ce) begin
         if (reg_rd && is_chan(reg_addr)) begin
            reg_rdata <= chan_all[chan_idx(reg_addr)*8 +: 8]; // RL1 RL5
         end else if (reg_rd) begin
            reg_rdata <= next_rdata;
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

endmodule

//--- acr_regs_checker.sv
// assertion checker for the channel and resampler register bank ports
`timescale 1ns/1ps
`include "acr_cfg.svh"

module acr_regs_checker (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        ce,
   input wire logic [6:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        chip_fault_in,
   input wire logic        init_done_in,
   input wire logic [3:0]  sat_fault_in,
   input wire logic        gpio_load_in,
   input wire logic [11:0] amp_gain_code,
   input wire logic [5:0]  vref_watch,
   input wire logic [5:0]  meter_receive,
   input wire logic [11:0] resample_int_ratio,
   input wire logic [15:0] resample_frac_ratio,
   input wire logic        resample_trigger_select,
   input wire logic        resample_applied
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // ========
   // helper logic
   // cycles since the last load request; saturates so a quiet bank never wraps
   logic [3:0] since_trig;
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         since_trig <= 4'hF;
      else if ((ce && reg_wr && reg_addr == 7'h64 && reg_wdata[0]) || gpio_load_in)
         since_trig <= 4'h0;
      else if (since_trig != 4'hF)
         since_trig <= since_trig + 4'h1;
   end

   // ========
   // channel setup writes reach the outputs two edges later
   sequence wr_ch0_s;
      ce && reg_wr && reg_addr == 7'h00;
   endsequence
   sequence wr_ch5_s;
      ce && reg_wr && reg_addr == 7'h05;
   endsequence

   chan0_fields_a: assert property (
      wr_ch0_s ##1 ce |=> amp_gain_code[1:0] == $past(reg_wdata[7:6], 2) &&
      vref_watch[0] == $past(reg_wdata[5], 2) && meter_receive[0] == $past(reg_wdata[4], 2))
      else $error("channel 0 outputs do not follow the write");
   chan5_fields_a: assert property (
      wr_ch5_s ##1 ce |=> amp_gain_code[11:10] == $past(reg_wdata[7:6], 2) &&
      vref_watch[5] == $past(reg_wdata[5], 2) && meter_receive[5] == $past(reg_wdata[4], 2))
      else $error("channel 5 outputs do not follow the write");

   // ========
   // read data of holes and reserved bits
   unmapped_zero_a: assert property (
      reg_rd && ce && ((reg_addr > 7'h05 && reg_addr < 7'h5F) || reg_addr > 7'h64) |=> reg_rdata == 8'h00)
      else $error("unmapped read returned nonzero");
   status_rsvd_a: assert property (
      reg_rd && ce && reg_addr == 7'h5F |=> reg_rdata[7:6] == 2'b00)
      else $error("status reserved bits nonzero");
   inthi_rsvd_a: assert property (
      reg_rd && ce && reg_addr == 7'h60 |=> reg_rdata[7:4] == 4'h0)
      else $error("integer ratio high reserved bits nonzero");
   loadctl_rsvd_a: assert property (
      reg_rd && ce && reg_addr == 7'h64 |=> reg_rdata[6:1] == 6'h00)
      else $error("load control reserved bits nonzero");

   // ========
   // ratio apply; the new ratio and the apply pulse leave the same edge
   int_applied_a: assert property (
      $changed(resample_int_ratio) && ce |-> resample_applied)
      else $error("integer ratio moved without apply pulse");
   frac_applied_a: assert property (
      $changed(resample_frac_ratio) && ce |-> resample_applied)
      else $error("fractional ratio moved without apply pulse");
   apply_pulse_a: assert property (
      resample_applied && ce |=> !resample_applied)
      else $error("apply pulse longer than one cycle");
   apply_cause_a: assert property (
      resample_applied |-> since_trig <= 4'd12)
      else $error("apply without a recent load request");
endmodule

//--- tb.sv
// self-checking bench for the channel and resampler register bank
`timescale 1ns/1ps
`include "acr_cfg.svh"

module tb;
   logic        clk, rst, ce, reg_wr, reg_rd, chip_fault_in, init_done_in, gpio_load_in;
   logic [6:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata;
   logic [3:0]  sat_fault_in;
   logic [11:0] amp_gain_code, resample_int_ratio;
   logic [5:0]  vref_watch, meter_receive;
   logic [15:0] resample_frac_ratio;
   logic        resample_trigger_select, resample_applied;
   int          err_total, n_checks;
   logic [6:0]  addr_tab [12] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h5F, 7'h60, 7'h61, 7'h62, 7'h63, 7'h64};
   logic [7:0]  rst_tab [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};

   acr_regs acr_regs_i (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chip_fault_in(chip_fault_in),
      .init_done_in(init_done_in), .sat_fault_in(sat_fault_in), .gpio_load_in(gpio_load_in),
      .amp_gain_code(amp_gain_code), .vref_watch(vref_watch), .meter_receive(meter_receive),
      .resample_int_ratio(resample_int_ratio), .resample_frac_ratio(resample_frac_ratio),
      .resample_trigger_select(resample_trigger_select), .resample_applied(resample_applied));

   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ========
   // compare, report and bus tasks
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe, so sample just past that edge
   task automatic rc(input logic [6:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk("read data", 16'(reg_rdata), 16'(e));
   endtask

   // bounded wait for the one-cycle apply pulse
   task automatic wait_applied;
      int i;
      i = 0;
      while (resample_applied !== 1'b1 && i < 20) begin
         @(posedge clk);
         #1;
         i++;
      end
      if (i == 20) begin
         err_total++;
         $display("BAD apply pulse expected 1 seen 0");
         end_sim;
      end
   endtask

   task automatic reset_vals;
      for (int i = 0; i < 12; i++)
         rc(addr_tab[i], rst_tab[i]);
      chk("int ratio", 16'(resample_int_ratio), 16'h0080);
      chk("frac ratio", resample_frac_ratio, 16'h0000);
      chk("gain", 16'(amp_gain_code), 16'h0000);
      chk("flags", 16'({vref_watch, meter_receive}), 16'h0000);
   endtask

   // channel pattern: gain code walks all four values, flags alternate, nibble varies
   function automatic logic [7:0] cv(input int c);
      return {c[1:0], c[0], ~c[0], c[3:0] ^ 4'hA};
   endfunction

   // ========
   // main sequence
   initial begin
      logic [7:0] v;
      rst = 1'b1;
      ce = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 7'h00;
      reg_wdata = 8'h00;
      chip_fault_in = 1'b0;
      init_done_in = 1'b0;
      sat_fault_in = 4'h0;
      gpio_load_in = 1'b0;
      err_total = 0;
      n_checks = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      reset_vals;
      // channel fields, written then read back and seen on the outputs
      for (int c = 0; c < 6; c++)
         wr(7'(c), cv(c));
      for (int c = 0; c < 6; c++) begin
         v = cv(c);
         rc(7'(c), v);
         chk("gain", 16'(amp_gain_code[2*c +: 2]), 16'(v[7:6]));
         chk("vref", 16'(vref_watch[c]), 16'(v[5]));
         chk("meter", 16'(meter_receive[c]), 16'(v[4]));
      end
      // refused writes and reserved bits
      wr(7'h5F, 8'hFF);
      rc(7'h5F, 8'h00);
      wr(7'h10, 8'hFF);
      rc(7'h10, 8'h00);
      wr(7'h60, 8'hFF);
      rc(7'h60, 8'h0F);
      wr(7'h64, 8'h7E);
      rc(7'h64, 8'h00);
      // status inputs pass through the synchronisers
      @(posedge clk);
      chip_fault_in <= 1'b1;
      sat_fault_in <= 4'h5;
      repeat (4) @(posedge clk);
      rc(7'h5F, 8'h25);
      @(posedge clk);
      chip_fault_in <= 1'b0;
      init_done_in <= 1'b1;
      sat_fault_in <= 4'hA;
      repeat (4) @(posedge clk);
      rc(7'h5F, 8'h1A);
      // software load: staged bytes stay inactive until the update bit rises
      wr(7'h60, 8'h0A);
      wr(7'h61, 8'hBC);
      wr(7'h62, 8'h12);
      wr(7'h63, 8'h34);
      repeat (3) @(posedge clk);
      #1;
      chk("int held", 16'(resample_int_ratio), 16'h0080);
      chk("frac held", resample_frac_ratio, 16'h0000);
      wr(7'h64, 8'h01);
      wait_applied;
      chk("int ratio", 16'(resample_int_ratio), 16'h0ABC);
      chk("frac ratio", resample_frac_ratio, 16'h1234);
      rc(7'h64, 8'h01);
      // pin load selected through bit 7
      wr(7'h64, 8'h80);
      wr(7'h61, 8'h55);
      #1;
      chk("select", 16'(resample_trigger_select), 16'h0001);
      chk("int held", 16'(resample_int_ratio), 16'h0ABC);
      @(posedge clk);
      gpio_load_in <= 1'b1;
      wait_applied;
      chk("int ratio", 16'(resample_int_ratio), 16'h0A55);
      @(posedge clk);
      gpio_load_in <= 1'b0;
      // a write while the clock enable is low must not land
      ce <= 1'b0;
      wr(7'h00, 8'hFF);
      @(posedge clk);
      ce <= 1'b1;
      rc(7'h00, cv(0));
      // second reset in mid-run
      @(posedge clk);
      init_done_in <= 1'b0;
      sat_fault_in <= 4'h0;
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      reset_vals;
      end_sim;
   end
endmodule

bind acr_regs acr_regs_checker acr_regs_checker_i (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .chip_fault_in(chip_fault_in), .init_done_in(init_done_in), .sat_fault_in(sat_fault_in),
   .gpio_load_in(gpio_load_in), .amp_gain_code(amp_gain_code), .vref_watch(vref_watch),
   .meter_receive(meter_receive), .resample_int_ratio(resample_int_ratio),
   .resample_frac_ratio(resample_frac_ratio), .resample_trigger_select(resample_trigger_select),
   .resample_applied(resample_applied));
